/* File: design/sia_alu.v */
// accumulator arithmetic unit
`timescale 1ns/1ps
`include "sia_defines.vh"
module sia_alu (
   input wire [7:0] op,
   input wire [31:0] accu,
   input wire [31:0] operand,
   output reg [31:0] result,
   output reg zero,
   output reg carry
);
   reg [32:0] wide;
   always @* begin
      wide = 33'h0;
      result = accu;
      case (op)
         `SIA_ACCU_CONST_OP_ADD: begin
            wide = {1'b0, accu} + {1'b0, operand};
            result = wide[31:0];
         end
         `SIA_ACCU_CONST_OP_SUB: begin
            wide = {1'b0, accu} - {1'b0, operand};
            result = wide[31:0];
         end
         `SIA_ACCU_CONST_OP_MUL: result = accu * operand;
         `SIA_ACCU_CONST_OP_AND: result = accu & operand;
         `SIA_ACCU_CONST_OP_OR: result = accu | operand;
         `SIA_ACCU_CONST_OP_XOR: result = accu ^ operand;
         `SIA_ACCU_CONST_OP_NOT: result = ~accu;
         `SIA_ACCU_CONST_OP_LOAD: result = operand;
         default: result = accu;
      endcase
      zero = (result == 32'h00000000);
      carry = wide[32];
   end
endmodule // sia_alu

/* File: design/sia_core.v */
// execution core: calculation commands, interrupt handling and rotate-right
`timescale 1ns/1ps
`include "sia_defines.vh"
module sia_core (
   input wire clock,
   input wire reset_n,
   input wire cmd_valid,
   input wire cmd_direct,
   input wire [7:0] cmd_op,
   input wire [7:0] cmd_type,
   input wire [7:0] cmd_bank,
   input wire [31:0] cmd_value,
   input wire [31:0] read_data,
   input wire [`SIA_NSRC-1:0] irq_event,
   input wire [31:0] pc_now,
   output reg [31:0] accu,
   output reg [31:0] xreg,
   output reg [1:0] flags,
   output reg in_handler,
   output reg irq_take,
   output reg [31:0] irq_target,
   output reg irq_resume,
   output reg [31:0] resume_pc,
   output reg par_write,
   output reg [1:0] par_kind,
   output reg [7:0] par_index,
   output reg [7:0] par_bank,
   output reg [31:0] par_data,
   output reg [1:0] motion_mode,
   output reg motion_dir,
   output reg [`SIA_NSRC-1:0] src_config_strobe,
   output reg [31:0] src_config_value
);
   wire [`SIA_NSRC-1:0] pend;
   wire [`SIA_NSRC-1:0] en;
   wire [`SIA_NSRC-1:0] vec_ok;
   wire [31:0] vec_addr [0:`SIA_NSRC-1];
   reg global_en;
   reg [31:0] save_accu;
   reg [31:0] save_x;
   reg [1:0] save_flags;
   reg [`SIA_NSRC-1:0] ev_s1;
   reg [`SIA_NSRC-1:0] ev_s2;
   reg [`SIA_NSRC-1:0] ev_d;
   reg [3:0] sel_idx;
   reg sel_hit;
   reg [3:0] num_idx;
   reg num_ok;
   reg [3:0] cfg_idx;
   reg cfg_ok;
   wire [31:0] alu_res;
   wire alu_zero;
   wire alu_carry;
   wire prog_cmd = cmd_valid & ~cmd_direct;
   wire is_read = (cmd_op == `SIA_OP_AXIS_READ) | (cmd_op == `SIA_OP_GLOBAL_READ) |
      (cmd_op == `SIA_OP_INPUT_READ) | (cmd_op == `SIA_OP_COORD_READ);
   wire [7:0] alu_op = (cmd_op == `SIA_OP_COMPARE) ? `SIA_ACCU_CONST_OP_SUB : cmd_type;
   wire [31:0] alu_b = (cmd_op == `SIA_OP_XREG) ? xreg : cmd_value;
   wire [`SIA_NSRC-1:0] ready = pend & en & vec_ok;
   // entry only between commands; the source is cleared on the same edge it is taken
   wire take_now = ~in_handler & global_en & sel_hit & ~cmd_valid & ~irq_take;
   integer k;

   sia_alu i_sia_alu (
      .op(alu_op),
      .accu(accu),
      .operand(alu_b),
      .result(alu_res),
      .zero(alu_zero),
      .carry(alu_carry)
   );

   // interrupt number to source index
   function [4:0] map_id;
      input [7:0] id;
      begin
         case (id)
            8'h00: map_id = 5'h10;
            8'h01: map_id = 5'h11;
            8'h02: map_id = 5'h12;
            8'h03: map_id = 5'h13;
            8'h0F: map_id = 5'h14;
            8'h1B: map_id = 5'h15;
            8'h1C: map_id = 5'h16;
            8'h27: map_id = 5'h17;
            8'h28: map_id = 5'h18;
            8'h29: map_id = 5'h19;
            8'h2A: map_id = 5'h1A;
            default: map_id = 5'h00;
         endcase
      end
   endfunction

   always @* begin
      {num_ok, num_idx} = map_id(cmd_type);
      {cfg_ok, cfg_idx} = map_id(cmd_type);
      sel_hit = |ready;
      sel_idx = 4'h0;
      // scan downward so the lowest ready index is left standing
      for (k = `SIA_NSRC - 1; k >= 0; k = k - 1) begin
         if (ready[k]) begin
            sel_idx = k[3:0];
         end
      end
   end

   // events come from other logic such as timers and pins, so synchronise
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ev_s1 <= {`SIA_NSRC{1'b0}};
         ev_s2 <= {`SIA_NSRC{1'b0}};
         ev_d <= {`SIA_NSRC{1'b0}};
      end else begin
         ev_s1 <= irq_event;
         ev_s2 <= ev_s1;
         ev_d <= ev_s2;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `SIA_NSRC; g = g + 1) begin : g_src
         reg pend_q;
         reg en_q;
         reg vec_ok_q;
         reg [31:0] addr_q;
         wire clr_now = take_now & ({28'h0000000, sel_idx} == g);
         wire hit = prog_cmd & num_ok & ({28'h0000000, num_idx} == g);
         assign pend[g] = pend_q;
         assign en[g] = en_q;
         assign vec_ok[g] = vec_ok_q;
         assign vec_addr[g] = addr_q;
         always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               pend_q <= 1'b0;
               en_q <= 1'b0;
               vec_ok_q <= 1'b0;
               addr_q <= 32'h00000000;
            end else begin
               // rising edge sets; new edge wins over the service clear
               if (ev_s2[g] & ~ev_d[g]) pend_q <= 1'b1;
               else if (clr_now) pend_q <= 1'b0;
               if (hit) begin
                  if (cmd_op == `SIA_OP_IRQ_EN) en_q <= 1'b1;
                  if (cmd_op == `SIA_OP_IRQ_DIS) en_q <= 1'b0;
                  if (cmd_op == `SIA_OP_IRQ_VECTOR_DEFINE) begin
                     addr_q <= cmd_value;
                     vec_ok_q <= 1'b1;
                  end
               end
            end
         end
      end
   endgenerate

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         accu <= 32'h00000000;
         xreg <= 32'h00000000;
         flags <= 2'h0;
         in_handler <= 1'b0;
         global_en <= 1'b0;
         save_accu <= 32'h00000000;
         save_x <= 32'h00000000;
         save_flags <= 2'h0;
         irq_take <= 1'b0;
         irq_target <= 32'h00000000;
         irq_resume <= 1'b0;
         resume_pc <= 32'h00000000;
         par_write <= 1'b0;
         par_kind <= 2'h0;
         par_index <= 8'h00;
         par_bank <= 8'h00;
         par_data <= 32'h00000000;
         motion_mode <= 2'h0;
         motion_dir <= 1'b0;
         src_config_strobe <= {`SIA_NSRC{1'b0}};
         src_config_value <= 32'h00000000;
      end else begin
         irq_take <= 1'b0;
         irq_resume <= 1'b0;
         par_write <= 1'b0;
         src_config_strobe <= {`SIA_NSRC{1'b0}};
         // one cycle pulse to the sequencer
         if (take_now) begin
            irq_take <= 1'b1;
            irq_target <= vec_addr[sel_idx];
            resume_pc <= pc_now;
            save_accu <= accu;
            save_x <= xreg;
            save_flags <= flags;
            in_handler <= 1'b1;
         end else if (cmd_valid) begin
            case (cmd_op)
               `SIA_OP_CONST, `SIA_OP_XREG: begin
                  if (cmd_op == `SIA_OP_CONST && cmd_type == `SIA_ACCU_CONST_OP_SWAP) begin
                     accu <= cmd_value;
                  end else if (cmd_op == `SIA_OP_XREG && cmd_type == `SIA_ACCU_CONST_OP_SWAP) begin
                     accu <= xreg;
                     xreg <= accu;
                  end else if (cmd_op == `SIA_OP_XREG && cmd_type == `SIA_ACCU_CONST_OP_TO_X) begin
                     xreg <= accu;
                  end else begin
                     accu <= alu_res;
                     flags <= {alu_carry, alu_zero};
                  end
               end
               `SIA_OP_COMPARE: flags <= {alu_carry, alu_zero};
               `SIA_OP_TO_AXIS, `SIA_OP_TO_GLOBAL, `SIA_OP_TO_COORD: begin
                  par_write <= 1'b1;
                  par_kind <= (cmd_op == `SIA_OP_TO_AXIS) ? 2'h0 : (cmd_op == `SIA_OP_TO_GLOBAL) ? 2'h1 : 2'h2;
                  par_index <= cmd_type;
                  par_bank <= cmd_bank;
                  par_data <= accu;
               end
               `SIA_OP_GLOBAL_WRITE: begin
                  par_write <= 1'b1;
                  par_kind <= 2'h1;
                  par_index <= cmd_type;
                  par_bank <= cmd_bank;
                  par_data <= cmd_value;
                  if (cmd_bank == `SIA_IRQ_BANK && cfg_ok) begin
                     src_config_strobe[cfg_idx] <= 1'b1;
                     src_config_value <= cmd_value;
                  end
               end
               `SIA_OP_IRQ_EN, `SIA_OP_IRQ_DIS: begin
                  if (prog_cmd && cmd_type == `SIA_GLOBAL_IRQ_ID)
                     global_en <= (cmd_op == `SIA_OP_IRQ_EN);
               end
               `SIA_OP_RETURN: begin
                  if (prog_cmd && in_handler) begin
                     accu <= save_accu;
                     xreg <= save_x;
                     flags <= save_flags;
                     in_handler <= 1'b0;
                     irq_resume <= 1'b1;
                  end
               end
               `SIA_OP_ROTATE_POS: begin
                  motion_mode <= `SIA_MODE_VELOCITY;
                  motion_dir <= 1'b1;
                  par_write <= 1'b1;
                  par_kind <= 2'h0;
                  par_index <= `SIA_AXIS_TARGET_VEL;
                  par_bank <= cmd_bank;
                  par_data <= cmd_value;
               end
               default: begin
                  if (is_read && prog_cmd) accu <= read_data;
               end
            endcase
         end
      end
   end
endmodule // sia_core

/* File: dv/script_interrupt_accumulator_bench.sv */
// self-checking bench of the script interrupt accumulator core
`timescale 1ns/1ps
`include "sia_defines.vh"
module script_interrupt_accumulator_bench;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   wire logic cmd_valid, cmd_direct, in_handler, irq_take, irq_resume, par_write, motion_dir;
   wire logic [7:0] cmd_op, cmd_type, cmd_bank, par_index, par_bank;
   wire logic [31:0] cmd_value, read_data, pc_now, accu, xreg, irq_target, resume_pc, par_data, src_config_value;
   wire logic [1:0] flags, par_kind, motion_mode;
   wire logic [11:0] irq_event, src_config_strobe;
   int n_mismatch = 0;
   int checks = 0;
   int n_take = 0;
   sia_core i_sia_core (.*);
   sia_host_model i_sia_host_model (.*);
   always #4 clock = ~clock;
   always @(posedge clock) begin
      if (irq_take === 1'b1)
         n_take <= n_take + 1;
   end
   task chk(input string what, input logic [63:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task cmd(input logic d, input logic [7:0] op, t, b, input logic [31:0] v, rd);
      i_sia_host_model.send(d, op, t, b, v, rd);
      #1;
   endtask
   task wait_take(input int n);
      for (int i = 0; i < 20 && n_take < n; i++)
         @(posedge clock);
      #1;
      chk("take", n_take, n);
   endtask
   task t_accu_const_op;
      logic [7:0] ops [3] = '{`SIA_OP_TO_AXIS, `SIA_OP_TO_GLOBAL, `SIA_OP_TO_COORD};
      cmd(0, `SIA_OP_ROTATE_POS, 8'h00, 8'h00, 32'h0000_03E8, '0);
      chk("rotate mode", {motion_mode, motion_dir}, 3'h3);
      chk("rotate par", {par_write, par_index, par_data}, {1'b1, 8'h02, 32'h0000_03E8});
      cmd(0, `SIA_OP_CONST, `SIA_ACCU_CONST_OP_LOAD, 8'h00, 32'h0000_0005, '0);
      cmd(0, `SIA_OP_CONST, `SIA_ACCU_CONST_OP_ADD, 8'h00, 32'h0000_0003, '0);
      cmd(0, `SIA_OP_XREG, `SIA_ACCU_CONST_OP_TO_X, 8'h00, '0, '0);
      chk("xreg", xreg, 32'h0000_0008);
      cmd(0, `SIA_OP_CONST, `SIA_ACCU_CONST_OP_LOAD, 8'h00, 32'h0000_0002, '0);
      cmd(0, `SIA_OP_XREG, `SIA_ACCU_CONST_OP_ADD, 8'h00, '0, '0);
      chk("x add", accu, 32'h0000_000A);
      for (int k = 0; k < 3; k++) begin
         cmd(0, ops[k], 8'h04, 8'h00, '0, '0);
         chk("copy", {par_write, par_kind, par_index, par_data}, {1'b1, k[1:0], 8'h04, 32'h0000_000A});
      end
      cmd(0, `SIA_OP_AXIS_READ, 8'h01, 8'h00, '0, 32'h0000_0055);
      chk("prog read", accu, 32'h0000_0055);
      cmd(1, `SIA_OP_GLOBAL_READ, 8'h01, 8'h00, '0, 32'h0000_0077);
      chk("host read", accu, 32'h0000_0055);
      cmd(0, `SIA_OP_CONST, `SIA_ACCU_CONST_OP_SUB, 8'h00, 32'h0000_0056, '0);
      chk("borrow", {accu, flags}, {32'hFFFF_FFFF, 2'h2});
      cmd(0, `SIA_OP_CONST, `SIA_ACCU_CONST_OP_ADD, 8'h00, 32'h0000_0056, '0);
      chk("wrap", accu, 32'h0000_0055);
   endtask
   task t_irq;
      cmd(0, `SIA_OP_IRQ_VECTOR_DEFINE, `SIA_TIMER_ZERO_IRQ_ID, 8'h00, 32'h0000_0040, '0);
      cmd(0, `SIA_OP_IRQ_VECTOR_DEFINE, 8'h03, 8'h00, 32'h0000_0080, '0);
      cmd(0, `SIA_OP_GLOBAL_WRITE, `SIA_TIMER_ZERO_IRQ_ID, `SIA_IRQ_BANK, 32'h0000_03E8, '0);
      chk("cfg", {src_config_strobe, src_config_value}, {12'h001, 32'h0000_03E8});
      chk("cfg par", {par_write, par_kind, par_bank}, {1'b1, 2'h1, 8'h03});
      cmd(0, `SIA_OP_IRQ_EN, `SIA_TIMER_ZERO_IRQ_ID, 8'h00, '0, '0);
      cmd(0, `SIA_OP_IRQ_EN, 8'h03, 8'h00, '0, '0);
      cmd(0, `SIA_OP_COMPARE, 8'h00, 8'h00, 32'h0000_0055, '0);
      i_sia_host_model.pulse(0);
      chk("no global", n_take, 0);
      cmd(0, `SIA_OP_IRQ_EN, `SIA_GLOBAL_IRQ_ID, 8'h00, '0, '0);
      wait_take(1);
      chk("entry", {in_handler, irq_target}, {1'b1, 32'h0000_0040});
      cmd(0, `SIA_OP_CONST, `SIA_ACCU_CONST_OP_LOAD, 8'h00, 32'h0000_0099, '0);
      cmd(0, `SIA_OP_XREG, `SIA_ACCU_CONST_OP_TO_X, 8'h00, '0, '0);
      cmd(0, `SIA_OP_COMPARE, 8'h00, 8'h00, 32'h0000_0011, '0);
      i_sia_host_model.pulse(3);
      chk("nesting", n_take, 1);
      cmd(1, `SIA_OP_RETURN, 8'h00, 8'h00, '0, '0);
      chk("host return", in_handler, 1'b1);
      cmd(0, `SIA_OP_RETURN, 8'h00, 8'h00, '0, '0);
      chk("resume", {irq_resume, flags[0], resume_pc}, {2'h3, 32'h0000_0100});
      chk("restore", {accu, xreg}, {32'h0000_0055, 32'h0000_0008});
      wait_take(2);
      chk("held", irq_target, 32'h0000_0080);
      cmd(0, `SIA_OP_RETURN, 8'h00, 8'h00, '0, '0);
      cmd(0, `SIA_OP_IRQ_DIS, `SIA_TIMER_ZERO_IRQ_ID, 8'h00, '0, '0);
      i_sia_host_model.pulse(0);
      chk("disabled", n_take, 2);
   endtask
   task complete_run;
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      t_accu_const_op;
      t_irq;
      complete_run;
   end
   // the whole sequence needs about a hundred cycles
   initial begin
      repeat (3000) @(posedge clock);
      n_mismatch++;
      complete_run;
   end
endmodule // script_interrupt_accumulator_bench

/* File: dv/sia_core_assertions.sv */
// concurrent checks on the core's ports
`timescale 1ns/1ps
`include "sia_defines.vh"
module sia_core_checker (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic cmd_direct,
   input wire logic [7:0] cmd_op,
   input wire logic [7:0] cmd_type,
   input wire logic [7:0] cmd_bank,
   input wire logic [31:0] cmd_value,
   input wire logic [31:0] read_data,
   input wire logic [31:0] accu,
   input wire logic [31:0] xreg,
   input wire logic in_handler,
   input wire logic irq_take,
   input wire logic irq_resume,
   input wire logic par_write,
   input wire logic [1:0] par_kind,
   input wire logic [7:0] par_index,
   input wire logic [31:0] par_data,
   input wire logic [1:0] motion_mode,
   input wire logic motion_dir,
   input wire logic [`SIA_NSRC-1:0] src_config_strobe,
   input wire logic [31:0] src_config_value
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   wire logic prog = cmd_valid && !cmd_direct;
   wire logic host = cmd_valid && cmd_direct;
   a_rotate_setup: assert property (cmd_valid && cmd_op == `SIA_OP_ROTATE_POS
      |=> motion_mode == `SIA_MODE_VELOCITY && motion_dir && par_write && par_index == `SIA_AXIS_TARGET_VEL
      && par_data == $past(cmd_value)) else $error("rotate");
   a_prog_read: assert property (prog && cmd_op == `SIA_OP_AXIS_READ |=> accu == $past(read_data))
      else $error("program read");
   a_host_read: assert property (host && (cmd_op == `SIA_OP_AXIS_READ || cmd_op == `SIA_OP_GLOBAL_READ)
      |=> $stable(accu)) else $error("host read");
   a_x_load: assert property (cmd_valid && cmd_op == `SIA_OP_XREG && cmd_type == `SIA_ACCU_CONST_OP_TO_X
      |=> xreg == $past(accu)) else $error("x load");
   a_copy_axis: assert property (cmd_valid && cmd_op == `SIA_OP_TO_AXIS
      |=> par_write && par_kind == 2'h0 && par_data == $past(accu)) else $error("axis copy");
   a_take_idle: assert property (irq_take |-> in_handler && !$past(cmd_valid) && !$past(in_handler))
      else $error("entry");
   a_return_resume: assert property (prog && cmd_op == `SIA_OP_RETURN && in_handler
      |=> irq_resume && !in_handler) else $error("return");
   a_host_ret_ignored: assert property (host && cmd_op == `SIA_OP_RETURN |=> !irq_resume)
      else $error("host return");
   a_cfg_strobe: assert property (cmd_valid && cmd_op == `SIA_OP_GLOBAL_WRITE && cmd_bank == `SIA_IRQ_BANK
      && cmd_type == 8'h00 |=> src_config_strobe[0] && src_config_value == $past(cmd_value)) else $error("config");
   c_take: cover property (irq_take);
   c_resume: cover property (irq_resume);
   c_rotate: cover property (cmd_valid && cmd_op == `SIA_OP_ROTATE_POS);
endmodule // sia_core_checker
bind sia_core sia_core_checker i_sia_core_checker (.*);

/* File: dv/sia_host_model.sv */
// host and event source model for the core's command side
`timescale 1ns/1ps
module sia_host_model (
   input wire logic clock,
   output logic cmd_valid,
   output logic cmd_direct,
   output logic [7:0] cmd_op,
   output logic [7:0] cmd_type,
   output logic [7:0] cmd_bank,
   output logic [31:0] cmd_value,
   output logic [31:0] read_data,
   output logic [11:0] irq_event,
   output logic [31:0] pc_now
);
   initial begin
      {cmd_valid, cmd_direct, cmd_op, cmd_type, cmd_bank, cmd_value, read_data, irq_event} = '0;
      pc_now = 32'h0000_0100;
   end
   // value and read data are valid only at the taking edge; inverted after so stale use shows
   task send(input logic d, input logic [7:0] op, t, b, input logic [31:0] v, rd);
      @(posedge clock);
      {cmd_valid, cmd_direct, cmd_op, cmd_type, cmd_bank, cmd_value, read_data} <= {1'b1, d, op, t, b, v, rd};
      @(posedge clock);
      cmd_valid <= 1'b0;
      {cmd_value, read_data} <= ~{v, rd};
   endtask
   task pulse(input int idx);
      @(posedge clock);
      irq_event[idx] <= 1'b1;
      repeat (4) @(posedge clock);
      irq_event[idx] <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
   endtask
endmodule // sia_host_model

/* File: include/sia_defines.vh */
// opcodes, interrupt numbers and field constants of the script interrupt accumulator
`ifndef SIA_DEFINES_VH
`define SIA_DEFINES_VH
`define SIA_OP_ROTATE_POS 8'h01
`define SIA_OP_AXIS_READ 8'h06
`define SIA_OP_GLOBAL_WRITE 8'h09
`define SIA_OP_GLOBAL_READ 8'h0A
`define SIA_OP_INPUT_READ 8'h0F
`define SIA_OP_CONST 8'h13
`define SIA_OP_COMPARE 8'h14
`define SIA_OP_IRQ_EN 8'h19
`define SIA_OP_IRQ_DIS 8'h1A
`define SIA_OP_COORD_READ 8'h1F
`define SIA_OP_XREG 8'h21
`define SIA_OP_TO_AXIS 8'h22
`define SIA_OP_TO_GLOBAL 8'h23
`define SIA_OP_IRQ_VECTOR_DEFINE 8'h25
`define SIA_OP_RETURN 8'h26
`define SIA_OP_TO_COORD 8'h27
`define SIA_IRQ_BANK 8'h03
`define SIA_GLOBAL_IRQ_ID 8'hFF
`define SIA_TIMER_ZERO_IRQ_ID 8'h00
`define SIA_AXIS_TARGET_VEL 8'h02
`define SIA_MODE_VELOCITY 2'h1
`define SIA_NSRC 12
// accu_const_op operation codes
`define SIA_ACCU_CONST_OP_ADD 8'h00
`define SIA_ACCU_CONST_OP_SUB 8'h01
`define SIA_ACCU_CONST_OP_MUL 8'h02
`define SIA_ACCU_CONST_OP_AND 8'h04
`define SIA_ACCU_CONST_OP_OR 8'h05
`define SIA_ACCU_CONST_OP_XOR 8'h06
`define SIA_ACCU_CONST_OP_NOT 8'h07
`define SIA_ACCU_CONST_OP_LOAD 8'h08
`define SIA_ACCU_CONST_OP_SWAP 8'h09
`define SIA_ACCU_CONST_OP_TO_X 8'h0A
`endif
